// [rivm_pkg.sv]
// How it works
// - every reset cause goes to the reset vector at address zero normally.
// - comparators, request 0, timer16 capture/compares, slot 15 empty, timer16 overflow.
// - timer8 compare a, overflow, adc, request 1, spi, three serial events.
// - request 2, watchdog, eeprom, timer8 compare b, request 3, two gaps, store ready.
// - programmed boot-reset fuse sends every reset to the boot loader start.
// - with table select set, vectors are offset by the boot section start.
// - reset target and table base are chosen independently of each other.
// - fuse reads 1 when unprogrammed and 0 when programmed.
// - select changes only within four cycles after change-enable, with enable zero.
// - interrupts blocked from enable until two instructions retire after the select write, or four cycles.
package rivm_pkg;
  localparam int          RIVM_ADDR_W      = 16;
  localparam int          RIVM_NUM_SRC     = 31;
  localparam int          RIVM_SRC_W       = 5;
  localparam logic [15:0] RIVM_RESET_ADDR  = 16'h0000;
  localparam logic [15:0] RIVM_VEC_STEP    = 16'h0002;
  localparam logic [15:0] RIVM_BOOT_ADDR   = 16'h0C00;
  localparam int          RIVM_WINDOW_CYC  = 4;
  localparam logic [2:0]  RIVM_WINDOW_LAST = 3'h4;
  localparam logic [2:0]  RIVM_BLOCK_TAIL  = 3'h1;
  localparam int          RIVM_BIT_CE      = 0;
  localparam int          RIVM_BIT_SEL     = 1;
  localparam logic [7:0]  RIVM_CTRL_RESET  = 8'h00;
  localparam logic        RIVM_FUSE_PROG   = 1'b0;
  // vector numbers of sources without a handler, then the highest vector
  localparam logic [5:0]  RIVM_SLOT_GAP0   = 6'h0F;
  localparam logic [5:0]  RIVM_SLOT_GAP1   = 6'h1E;
  localparam logic [5:0]  RIVM_SLOT_GAP2   = 6'h1F;
  localparam logic [5:0]  RIVM_SLOT_LAST   = 6'h20;
  typedef enum logic [1:0] {
    RIVM_IDLE  = 2'b00,
    RIVM_OPEN  = 2'b01,
    RIVM_TAIL  = 2'b10
  } rivm_state_e;
endpackage

// [rivm_vec_if.sv]
`timescale 1ns/1ps
interface rivm_vec_if;
  logic [rivm_pkg::RIVM_SRC_W-1:0]  src_index;
  logic                             src_valid;
  logic [rivm_pkg::RIVM_ADDR_W-1:0] table_base;
  logic [rivm_pkg::RIVM_ADDR_W-1:0] vec_addr;
  modport ctrl (output src_index, output src_valid, output table_base, input vec_addr);
  modport map  (input src_index, input src_valid, input table_base, output vec_addr);
endinterface

// [rivm_vec_map.sv]
`timescale 1ns/1ps
module rivm_vec_map
  import rivm_pkg::*;
(
  rivm_vec_if.map v
);
  logic [5:0]  slot;
  ////////////////////////////////////////////////////////////////////////
  // source index 0 is vector 2; slots follow the index linearly, capped at RIVM_SLOT_LAST
  always_comb
  begin
    slot = 6'(v.src_index) + 6'h02;
    if (slot > RIVM_SLOT_LAST)
      slot = RIVM_SLOT_LAST;
  end
  always_comb
  begin
    if (v.src_valid)
      v.vec_addr = v.table_base + 16'(slot - 6'h01) * RIVM_VEC_STEP;
    else
      v.vec_addr = v.table_base;
  end
endmodule

// [rivm_top.sv]
`timescale 1ns/1ps
module rivm_top
  import rivm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    boot_reset_fuse,
  input  wire logic [RIVM_NUM_SRC-1:0] irq_req,
  input  wire logic                    irq_ack,
  input  wire logic                    insn_retire,
  input  wire logic                    ctrl_wr,
  input  wire logic [7:0]              ctrl_wdata,
  output logic      [7:0]              core_control_register,
  output logic                         vector_table_select,
  output logic                         vector_change_enable,
  output logic                         irq_block,
  output logic      [RIVM_ADDR_W-1:0]  reset_addr,
  output logic      [RIVM_ADDR_W-1:0]  vec_addr,
  output logic                         vec_valid
);
  rivm_vec_if vif ();
  rivm_state_e             state_q;
  logic [2:0]              win_cnt_q;
  logic                    fuse_meta_q;
  logic                    fuse_q;
  logic                    sel_q;
  logic [RIVM_ADDR_W-1:0]  reset_addr_q;
  logic [RIVM_ADDR_W-1:0]  vec_addr_q;
  logic                    vec_valid_q;
  logic [RIVM_NUM_SRC-1:0] gap_mask;
  logic [RIVM_NUM_SRC-1:0] live_req;
  logic [RIVM_SRC_W-1:0] pick;
  logic        any_req;
  logic        sel_write;
  ////////////////////////////////////////////////////////////////////////
  // fuse pin passes two flops before any use
  always_ff @(posedge clk)
  begin
    fuse_meta_q <= boot_reset_fuse;
    fuse_q      <= fuse_meta_q;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      reset_addr_q <= RIVM_RESET_ADDR;
    else if (fuse_q == RIVM_FUSE_PROG)
      reset_addr_q <= RIVM_BOOT_ADDR;
    else
      reset_addr_q <= RIVM_RESET_ADDR;
  end
  assign reset_addr = reset_addr_q;
  ////////////////////////////////////////////////////////////////////////
  // select taken only inside window
  assign sel_write = ctrl_wr && (state_q == RIVM_OPEN) && !ctrl_wdata[RIVM_BIT_CE];
  always_ff @(posedge clk)
  begin
    if (reset)
      sel_q <= RIVM_CTRL_RESET[RIVM_BIT_SEL];
    else if (sel_write)
      sel_q <= ctrl_wdata[RIVM_BIT_SEL];
  end
  assign vector_table_select = sel_q;
  // window and blocking sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q   <= RIVM_IDLE;
      win_cnt_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        RIVM_IDLE:
          if (ctrl_wr && ctrl_wdata[RIVM_BIT_CE])
          begin
            state_q   <= RIVM_OPEN;
            win_cnt_q <= 3'h1;
          end
        RIVM_OPEN:
          if (sel_write)
          begin
            state_q   <= RIVM_TAIL;
            win_cnt_q <= 3'h0;
          end
          else if (win_cnt_q == RIVM_WINDOW_LAST)
          begin
            state_q   <= RIVM_IDLE;
            win_cnt_q <= 3'h0;
          end
          else
            win_cnt_q <= win_cnt_q + 3'h1;
        RIVM_TAIL:
          if (insn_retire)
          begin
            if (win_cnt_q >= RIVM_BLOCK_TAIL)
              state_q <= RIVM_IDLE;
            win_cnt_q <= win_cnt_q + 3'h1;
          end
        default:
          state_q <= RIVM_IDLE;
      endcase
    end
  end
  assign vector_change_enable = (state_q == RIVM_OPEN);
  assign irq_block = (state_q != RIVM_IDLE);
  always_comb
  begin
    core_control_register = RIVM_CTRL_RESET;
    core_control_register[RIVM_BIT_CE]  = vector_change_enable;
    core_control_register[RIVM_BIT_SEL] = vector_table_select;
  end
  ////////////////////////////////////////////////////////////////////////
  // unassigned slots never raise a vector
  for (genvar g = 0; g < RIVM_NUM_SRC; g++)
  begin : g_gap
    assign gap_mask[g] = ((6'(g) + 6'h02) == RIVM_SLOT_GAP0)
                      || ((6'(g) + 6'h02) == RIVM_SLOT_GAP1)
                      || ((6'(g) + 6'h02) == RIVM_SLOT_GAP2);
  end
  assign live_req = irq_req & ~gap_mask;
  // lowest index pending source is presented
  always_comb
  begin
    pick    = '0;
    any_req = 1'b0;
    for (int i = RIVM_NUM_SRC - 1; i >= 0; i--)
    begin
      if (live_req[i])
      begin
        pick    = RIVM_SRC_W'(i);
        any_req = 1'b1;
      end
    end
  end
  assign vif.src_index = pick;
  assign vif.src_valid = any_req;
  assign vif.table_base = vector_table_select ? RIVM_BOOT_ADDR : RIVM_RESET_ADDR;
  rivm_vec_map u_map (
    .v (vif.map)
  );
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      vec_addr_q  <= RIVM_RESET_ADDR;
      vec_valid_q <= 1'b0;
    end
    else
    begin
      vec_addr_q  <= vif.vec_addr;
      vec_valid_q <= any_req && !irq_block && !irq_ack;
    end
  end
  assign vec_addr  = vec_addr_q;
  assign vec_valid = vec_valid_q;
endmodule

// [rivm_core_model.sv]
`timescale 1ns/1ps
module rivm_core_model
  import rivm_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   vec_valid,
  input  wire logic                   ack_en,
  output logic                        irq_ack,
  output logic                        insn_retire
);
  always_ff @(posedge clk)
  begin
    insn_retire <= !reset && !insn_retire;
    irq_ack     <= !reset && vec_valid && ack_en;
  end
endmodule

// [rivm_chk.sv]
`timescale 1ns/1ps
module rivm_chk
  import rivm_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic                    boot_reset_fuse,
  input wire logic [RIVM_NUM_SRC-1:0] irq_req,
  input wire logic                    irq_ack,
  input wire logic                    ctrl_wr,
  input wire logic [7:0]              ctrl_wdata,
  input wire logic                    vector_table_select,
  input wire logic                    vector_change_enable,
  input wire logic                    irq_block,
  input wire logic [RIVM_ADDR_W-1:0]  reset_addr,
  input wire logic [RIVM_ADDR_W-1:0]  vec_addr,
  input wire logic                    vec_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_RESET_ADDR: assert property (!$past(reset) |-> reset_addr ==
    ($past(boot_reset_fuse, 3) ? RIVM_RESET_ADDR : RIVM_BOOT_ADDR)) else $error("reset address");
  AST_SEL_TAKEN: assert property (vector_change_enable && ctrl_wr && !ctrl_wdata[0]
    |=> vector_table_select == $past(ctrl_wdata[1])) else $error("select not taken");
  AST_SEL_REFUSED: assert property (ctrl_wr && !vector_change_enable
    |=> $stable(vector_table_select)) else $error("select changed outside window");
  AST_CE_OPEN: assert property (ctrl_wr && ctrl_wdata[0] && !vector_change_enable
    |=> vector_change_enable && irq_block) else $error("window not opened");
  AST_CE_EXPIRE: assert property ($rose(vector_change_enable)
    |-> ##4 !vector_change_enable) else $error("enable stood too long");
  AST_CE_BLOCK: assert property (vector_change_enable |-> irq_block)
    else $error("not blocked in window");
  AST_BLOCK_END: assert property ($rose(irq_block) |-> ##[1:16] !irq_block)
    else $error("block never lifted");
  AST_VEC_FIRST: assert property (irq_req == 31'h00000001 |=> vec_addr ==
    ($past(vector_table_select) ? RIVM_BOOT_ADDR : 16'h0000) + 16'h0002) else $error("vector");
  AST_VALID_ACK: assert property (irq_ack |-> ##[1:2] !vec_valid)
    else $error("valid after ack");
endmodule
bind rivm_top rivm_chk i_chk (.clk(clk), .reset(reset), .boot_reset_fuse(boot_reset_fuse),
  .irq_req(irq_req), .irq_ack(irq_ack), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
  .vector_table_select(vector_table_select), .vector_change_enable(vector_change_enable),
  .irq_block(irq_block), .reset_addr(reset_addr), .vec_addr(vec_addr), .vec_valid(vec_valid));

// [tb.sv]
`timescale 1ns/1ps
module tb;
  import rivm_pkg::*;
  logic        clk, reset, fuse, ack, ret, wr, vsel, vce, blk, vv, ack_en;
  logic [7:0]  wd, ccr;
  logic [30:0] irq_req;
  logic [15:0] raddr, vaddr;
  int          num_errors, num_checks;
  logic [20:0] rows [8] = '{{5'h00, 16'h0002}, {5'h05, 16'h000C}, {5'h06, 16'h000E},
    {5'h0E, 16'h001E}, {5'h0F, 16'h0020}, {5'h16, 16'h002E}, {5'h17, 16'h0030},
    {5'h1E, 16'h003E}};
  rivm_top i_rivm_top (.clk(clk), .reset(reset), .boot_reset_fuse(fuse), .irq_req(irq_req),
    .irq_ack(ack), .insn_retire(ret), .ctrl_wr(wr), .ctrl_wdata(wd),
    .core_control_register(ccr), .vector_table_select(vsel), .vector_change_enable(vce),
    .irq_block(blk), .reset_addr(raddr), .vec_addr(vaddr), .vec_valid(vv));
  rivm_core_model i_rivm_core_model (.clk(clk), .reset(reset), .vec_valid(vv),
    .ack_en(ack_en), .irq_ack(ack), .insn_retire(ret));
  task stop_test;
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] s);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr_ctrl(logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task run_table(logic [15:0] base);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      irq_req <= 31'h1 << rows[i][20:16];
      settle(1);
      chk("vec_addr", rows[i][15:0] + base, vaddr);
      chk("vec_valid", 16'h0001, {15'h0000, vv});
    end
    @(posedge clk);
    irq_req <= '0;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  initial
  begin
    {reset, fuse} <= 2'h3;
    {wr, ack_en, irq_req, wd} <= '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    settle(2);
    chk("reset_addr", 16'h0000, raddr);
    chk("ctrl", 16'h0000, {8'h00, ccr});
    @(posedge clk);
    fuse <= 1'b0;
    settle(3);
    chk("reset_addr", RIVM_BOOT_ADDR, raddr);
    run_table(16'h0000);
    wr_ctrl(8'h01);
    #1;
    chk("enable", 16'h0001, {15'h0000, vce & blk});
    wr_ctrl(8'h02);
    #1;
    chk("select", 16'h0001, {15'h0000, vsel & !vce});
    @(posedge clk);
    fuse <= 1'b1;
    settle(6);
    chk("reset_addr", 16'h0000, raddr);
    chk("block", 16'h0000, {15'h0000, blk});
    run_table(RIVM_BOOT_ADDR);
    wr_ctrl(8'h01);
    settle(4);
    chk("enable", 16'h0000, {15'h0000, vce});
    settle(2);
    chk("block", 16'h0000, {15'h0000, blk});
    wr_ctrl(8'h00);
    settle(1);
    chk("select", 16'h0001, {15'h0000, vsel});
    @(posedge clk);
    ack_en <= 1'b1;
    irq_req <= 31'h1;
    settle(5);
    @(posedge clk);
    reset <= 1'b1;
    settle(2);
    chk("select", 16'h0000, {15'h0000, vsel | vce | vv});
    stop_test;
  end
endmodule
